/* File: rtl/eeprom_link_pkg.sv */
package eeprom_link_pkg;
   // arbitrary device type code
   localparam logic [3:0] DEV_TYPE = 4'h6;
   localparam int CLK_HZ = 50000000;
   localparam int WRITE_MS = 10;
   localparam int WRITE_CYCLES = CLK_HZ / 1000 * WRITE_MS;
   localparam int SCL_KHZ = 100;
   localparam int SCL_HALF = CLK_HZ / (SCL_KHZ * 1000) / 2;
   localparam int PAGE_BUF = 8;
   localparam int MEM_WORDS = 512;
   localparam int BIT_PAGE = 1;
   localparam int BIT_RD = 0;
   localparam logic [7:0] MEM_RESET = 8'hFF;
endpackage

/* File: rtl/eeprom_link_if.sv */
`timescale 1ns/100ps
interface eeprom_link_if;
   logic scl;
   logic sda_m_out;
   logic sda_m_oe;
   logic sda_s_out;
   logic sda_s_oe;
   wire logic sda = !((sda_m_oe && !sda_m_out) || (sda_s_oe && !sda_s_out));
   modport dev (input scl, input sda, output sda_s_out, output sda_s_oe);
   modport host (output scl, input sda, output sda_m_out, output sda_m_oe);
endinterface

/* File: rtl/two_wire_eeprom_slave.sv */
`timescale 1ns/100ps
module two_wire_eeprom_slave
#(
   parameter int WRITE_TIME = eeprom_link_pkg::WRITE_CYCLES
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // straps
   input wire logic strap_select_low,
   input wire logic strap_select_high,
   input wire logic unused_strap_input,
   // bus
   eeprom_link_if.dev link,
   // status
   output logic busy
);
   import eeprom_link_pkg::*;

   typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_WORD, S_WORD_ACK, S_DATA, S_DATA_ACK,
      S_TX, S_TX_ACK, S_WAIT} state_t;

   state_t state_reg;
   logic [7:0] mem [0:MEM_WORDS-1];
   logic [7:0] pbuf [0:PAGE_BUF-1];
   logic scl_reg, sda_reg, scl_d_reg, sda_d_reg;
   logic [7:0] shift_reg;
   logic [3:0] bit_reg;
   logic [7:0] cnt_reg;
   logic page_reg;
   logic [2:0] nbuf_reg;
   logic [3:0] nwr_reg;
   logic [8:0] wbase_reg;
   logic [31:0] timer_reg;
   logic sda_lo_reg;
   logic start_ev, stop_ev, rise_ev, fall_ev, addr_ok;
   logic rd_reg;
   logic tx_load;

   // lines are synchronous by assumption; one delay stage gives edges
   always_ff @(posedge ref_clk) begin
      scl_reg <= link.scl;
      sda_reg <= link.sda;
      scl_d_reg <= scl_reg;
      sda_d_reg <= sda_reg;
   end

   assign start_ev = scl_reg && scl_d_reg && sda_d_reg && !sda_reg;
   assign stop_ev = scl_reg && scl_d_reg && !sda_d_reg && sda_reg;
   assign rise_ev = scl_reg && !scl_d_reg;
   assign fall_ev = !scl_reg && scl_d_reg;
   assign addr_ok = shift_reg[7:4] == DEV_TYPE &&
      shift_reg[3:2] == {strap_select_high, strap_select_low};

   // next read byte is fetched on the fall that opens its first bit
   assign tx_load = fall_ev && ((state_reg == S_ADDR_ACK && rd_reg) ||
      (state_reg == S_TX_ACK && !shift_reg[0]));
   assign busy = timer_reg != 32'h0;
   assign link.sda_s_out = 1'b0;
   assign link.sda_s_oe = sda_lo_reg;

   // nine clocks per byte; count clears on the fall closing the ack clock
   always_ff @(posedge ref_clk) begin
      if (!resetn || start_ev) begin
         bit_reg <= 4'h0;
      end else if (rise_ev) begin
         bit_reg <= bit_reg + 4'h1;
      end else if (fall_ev && bit_reg == 4'h9) begin
         bit_reg <= 4'h0;
      end
   end

   // bit shifter: sample on rise, or load and shift out on fall when sending
   always_ff @(posedge ref_clk) begin
      if (rise_ev && state_reg != S_TX) begin
         shift_reg <= {shift_reg[6:0], sda_reg};
      end else if (tx_load) begin
         shift_reg <= mem[{page_reg, cnt_reg}];
      end else if (fall_ev && state_reg == S_TX) begin
         shift_reg <= {shift_reg[6:0], 1'b1};
      end
   end

   // main sequencer; drive changes only after a fall of the clock
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= S_IDLE;
         sda_lo_reg <= 1'b0;
         rd_reg <= 1'b0;
         cnt_reg <= 8'h00;
         page_reg <= 1'b0;
         nbuf_reg <= 3'h0;
         nwr_reg <= 4'h0;
         wbase_reg <= 9'h000;
      end else if (busy) begin
         state_reg <= S_IDLE;
         sda_lo_reg <= 1'b0;
      end else if (start_ev) begin
         state_reg <= S_ADDR;
         sda_lo_reg <= 1'b0;
         nwr_reg <= 4'h0;
      end else if (stop_ev) begin
         // byte count kept: the timed commit still needs it
         state_reg <= S_IDLE;
         sda_lo_reg <= 1'b0;
      end else if (fall_ev) begin
         case (state_reg)
            S_ADDR: begin
               if (bit_reg == 4'h8) begin
                  if (addr_ok) begin
                     sda_lo_reg <= 1'b1;
                     page_reg <= shift_reg[BIT_PAGE];
                     rd_reg <= shift_reg[BIT_RD];
                     state_reg <= S_ADDR_ACK;
                  end else begin
                     state_reg <= S_IDLE;
                  end
               end
            end
            S_ADDR_ACK: begin
               if (rd_reg) begin
                  sda_lo_reg <= !mem[{page_reg, cnt_reg}][7];
                  state_reg <= S_TX;
               end else begin
                  sda_lo_reg <= 1'b0;
                  state_reg <= S_WORD;
               end
            end
            S_WORD: begin
               if (bit_reg == 4'h8) begin
                  sda_lo_reg <= 1'b1;
                  cnt_reg <= shift_reg;
                  wbase_reg <= {page_reg, shift_reg};
                  nbuf_reg <= shift_reg[2:0];
                  state_reg <= S_WORD_ACK;
               end
            end
            S_WORD_ACK, S_DATA_ACK: begin
               sda_lo_reg <= 1'b0;
               state_reg <= S_DATA;
            end
            S_DATA: begin
               if (bit_reg == 4'h8) begin
                  sda_lo_reg <= 1'b1;
                  nbuf_reg <= nbuf_reg + 3'h1;
                  cnt_reg <= {cnt_reg[7:3], cnt_reg[2:0] + 3'h1};
                  if (nwr_reg != 4'h8) begin
                     nwr_reg <= nwr_reg + 4'h1;
                  end
                  state_reg <= S_DATA_ACK;
               end
            end
            S_TX: begin
               if (bit_reg == 4'h8) begin
                  sda_lo_reg <= 1'b0;
                  state_reg <= S_TX_ACK;
                  cnt_reg <= cnt_reg + 8'h01;
               end else begin
                  sda_lo_reg <= !shift_reg[6];
               end
            end
            S_TX_ACK: begin
               if (shift_reg[0]) begin
                  state_reg <= S_WAIT;
                  sda_lo_reg <= 1'b0;
               end else begin
                  state_reg <= S_TX;
                  sda_lo_reg <= !mem[{page_reg, cnt_reg}][7];
               end
            end
            default: begin
               sda_lo_reg <= 1'b0;
            end
         endcase
      end
   end

   // ack bit lands in shift_reg[0] during the master's ninth clock
   always_ff @(posedge ref_clk) begin
      if (state_reg == S_DATA && fall_ev && bit_reg == 4'h8) begin
         pbuf[nbuf_reg] <= shift_reg;
      end
   end

   // stop after data starts the timed write of the buffered bytes
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         timer_reg <= 32'h0;
      end else if (stop_ev && !busy && nwr_reg != 4'h0 &&
            (state_reg == S_DATA || state_reg == S_DATA_ACK)) begin
         timer_reg <= 32'(WRITE_TIME);
      end else if (busy) begin
         timer_reg <= timer_reg - 32'h1;
      end
   end

   // array commit at end of write; the page stays within its 8-byte row
   always_ff @(posedge ref_clk) begin
      if (timer_reg == 32'h1) begin
         for (int i = 0; i < PAGE_BUF; i++) begin
            if (i < int'(nwr_reg)) begin
               mem[{wbase_reg[8:3], 3'(wbase_reg[2:0] + 3'(i))}] <=
                  pbuf[3'(wbase_reg[2:0] + 3'(i))];
            end
         end
      end
   end
endmodule

/* File: rtl/two_wire_eeprom_master.sv */
`timescale 1ns/100ps
module two_wire_eeprom_master
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // user command: one byte per request
   input wire logic cmd_valid,
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire logic cmd_read,
   input wire logic cmd_ack,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   // result
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_acked,
   // bus
   eeprom_link_if.host link
);
   import eeprom_link_pkg::*;

   typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mstate_t;
   mstate_t state_reg;
   logic [15:0] div_reg;
   logic tick;
   logic [1:0] phase_reg;
   logic [3:0] bit_reg;
   logic [8:0] sh_reg;
   logic stop_reg, read_reg, scl_reg, sda_reg;

   assign tick = div_reg == 16'(SCL_HALF - 1);
   assign cmd_ready = state_reg == M_IDLE;
   assign link.scl = scl_reg;
   assign link.sda_m_out = 1'b0;
   assign link.sda_m_oe = !sda_reg;

   always_ff @(posedge ref_clk) begin
      if (!resetn || tick) begin
         div_reg <= 16'h0;
      end else begin
         div_reg <= div_reg + 16'h1;
      end
   end

   // bit quarter phases: 0 low-set data, 1 rise, 2 high-sample, 3 fall
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg <= M_IDLE;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_acked <= 1'b0;
         phase_reg <= 2'h0;
         bit_reg <= 4'h0;
         sh_reg <= 9'h1FF;
         stop_reg <= 1'b0;
         read_reg <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         case (state_reg)
            M_IDLE: begin
               if (cmd_valid) begin
                  // read: release 8 bits, then ack low or nack high
                  sh_reg <= cmd_read ? {8'hFF, !cmd_ack} : {cmd_data, 1'b1};
                  read_reg <= cmd_read;
                  stop_reg <= cmd_stop;
                  bit_reg <= 4'h0;
                  phase_reg <= 2'h0;
                  state_reg <= cmd_start ? M_START : M_BIT;
               end
            end
            M_START: if (tick) begin
               phase_reg <= phase_reg + 2'h1;
               case (phase_reg)
                  2'h0: sda_reg <= 1'b1;
                  2'h1: scl_reg <= 1'b1;
                  2'h2: sda_reg <= 1'b0;
                  default: begin
                     scl_reg <= 1'b0;
                     state_reg <= M_BIT;
                  end
               endcase
            end
            M_BIT: if (tick) begin
               phase_reg <= phase_reg + 2'h1;
               case (phase_reg)
                  2'h0: sda_reg <= sh_reg[8];
                  2'h1: scl_reg <= 1'b1;
                  2'h2: sh_reg <= {sh_reg[7:0], link.sda};
                  default: begin
                     scl_reg <= 1'b0;
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == 4'h7 && read_reg) begin
                        rsp_data <= sh_reg[7:0];
                     end
                     if (bit_reg == 4'h8) begin
                        rsp_acked <= !sh_reg[0];
                        rsp_valid <= 1'b1;
                        state_reg <= stop_reg ? M_STOP : M_IDLE;
                     end
                  end
               endcase
            end
            default: if (tick) begin
               phase_reg <= phase_reg + 2'h1;
               case (phase_reg)
                  2'h0: sda_reg <= 1'b0;
                  2'h1: scl_reg <= 1'b1;
                  2'h2: sda_reg <= 1'b1;
                  default: state_reg <= M_IDLE;
               endcase
            end
         endcase
      end
   end
endmodule

/* File: dv/two_wire_eeprom_slave_checker.sv */
`timescale 1ns/100ps
module two_wire_eeprom_slave_checker
#(
   parameter int WRITE_TIME = 200
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // link
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_out,
   input wire logic sda_s_oe,
   // status
   input wire logic busy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   int busy_cnt;
   // counts the write cycle; a wedged timer shows up as an overrun
   always_ff @(posedge ref_clk) begin
      if (!resetn || !busy) begin
         busy_cnt <= 0;
      end else begin
         busy_cnt <= busy_cnt + 1;
      end
   end
   sequence bus_idle;
      scl && sda;
   endsequence
   sequence pull_held;
      sda_s_oe [*8];
   endsequence
   oe_move_low_a: assert property ($changed(sda_s_oe) |-> !scl)
      else $error("slave data moved while clock high");
   oe_rise_late_a: assert property ($rose(sda_s_oe) |-> !$past(scl))
      else $error("slave drive began without a clock fall first");
   pull_held_a: assert property ($rose(scl) && sda_s_oe |-> pull_held)
      else $error("slave drive dropped during clock high");
   open_drain_a: assert property (sda_s_oe |-> !sda_s_out)
      else $error("slave drove data high");
   busy_quiet_a: assert property (busy |-> !sda_s_oe)
      else $error("slave answered while writing");
   busy_after_stop_a: assert property ($rose(busy) |-> bus_idle)
      else $error("write started without a stop");
   busy_hold_a: assert property ($rose(busy) |=> busy [*8])
      else $error("write cycle cut short");
   write_bound_a: assert property (busy_cnt <= WRITE_TIME)
      else $error("write cycle overran");
endmodule

/* File: dv/two_wire_eeprom_slave_tb_top.sv */
`timescale 1ns/100ps
module two_wire_eeprom_slave_tb_top;
   import eeprom_link_pkg::*;
   localparam int WT = 11000;
   localparam logic [7:0] ADR_W = {DEV_TYPE, 2'b01, 1'b0, 1'b0};
   localparam logic [7:0] ADR_R = {DEV_TYPE, 2'b01, 1'b0, 1'b1};
   localparam logic [7:0] ADR_X = {DEV_TYPE, 2'b10, 1'b0, 1'b0};
   logic ref_clk = 0;
   logic resetn = 0;
   logic cmd_valid = 0, cmd_start = 0, cmd_stop = 0, cmd_read = 0, cmd_ack = 0;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ready, rsp_valid, rsp_acked, busy;
   logic [7:0] rsp_data;
   logic [7:0] q;
   logic a;
   int miscompares = 0;
   int checks_done = 0;
   eeprom_link_if link();
   two_wire_eeprom_slave #(.WRITE_TIME(WT)) u_two_wire_eeprom_slave (.ref_clk(ref_clk),
      .resetn(resetn), .strap_select_low(1'b1), .strap_select_high(1'b0),
      .unused_strap_input(1'b0), .link(link), .busy(busy));
   two_wire_eeprom_master u_two_wire_eeprom_master (.ref_clk(ref_clk), .resetn(resetn),
      .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
      .cmd_read(cmd_read), .cmd_ack(cmd_ack), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_acked(rsp_acked), .link(link));
   two_wire_eeprom_slave_checker #(.WRITE_TIME(WT)) u_checker (.ref_clk(ref_clk),
      .resetn(resetn), .scl(link.scl), .sda(link.sda), .sda_s_out(link.sda_s_out),
      .sda_s_oe(link.sda_s_oe), .busy(busy));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one byte on the bus; waits for the master's result pulse
   task automatic xfer(input logic st, sp, rd, ak, input logic [7:0] d);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 5000) begin
         @(negedge ref_clk);
         n++;
      end
      {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_data} = {1'b1, st, sp, rd, ak, d};
      @(negedge ref_clk);
      cmd_valid = 0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 12000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 12000) begin
         miscompares++;
      end
      q = rsp_data;
      a = rsp_acked;
   endtask
   task automatic wait_busy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < WT + 2000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= WT + 2000) begin
         miscompares++;
      end
   endtask
   // word 07 then wrap of the low three bits onto 00
   task automatic test_page_write;
      xfer(1, 0, 0, 0, ADR_W);
      chk(a, 1'b1);
      xfer(0, 0, 0, 0, 8'h07);
      chk(a, 1'b1);
      xfer(0, 0, 0, 0, 8'h5A);
      chk(a, 1'b1);
      xfer(0, 1, 0, 0, 8'hC3);
      chk(a, 1'b1);
      wait_busy(1'b1);
      chk(busy, 1'b1);
   endtask
   task automatic test_poll_busy;
      xfer(1, 1, 0, 0, ADR_W);
      chk(a, 1'b0);
      chk(busy, 1'b1);
      wait_busy(1'b0);
      chk(busy, 1'b0);
   endtask
   task automatic test_bad_strap;
      xfer(1, 1, 0, 0, ADR_X);
      chk(a, 1'b0);
   endtask
   task automatic test_random_read;
      xfer(1, 0, 0, 0, ADR_W);
      chk(a, 1'b1);
      xfer(0, 0, 0, 0, 8'h00);
      chk(a, 1'b1);
      xfer(1, 0, 0, 0, ADR_R);
      chk(a, 1'b1);
      xfer(0, 1, 1, 0, 8'h00);
      chk(q, 8'hC3);
   endtask
   task automatic complete_run;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge ref_clk);
      resetn = 1;
      test_page_write();
      test_poll_busy();
      test_bad_strap();
      test_random_read();
      complete_run();
   end
   // about a fifth above the expected run
   initial begin
      repeat (120000) @(posedge ref_clk);
      miscompares++;
      complete_run();
   end
endmodule
